// [usb_frame_regs.sv]
// frame tracking, function address, table base and endpoint rx control
// assumes a protocol engine on the same clock drives token and event pulses
`timescale 1ns/1ps
`default_nettype none
`include "usb_frame_map.svh"
module usb_frame_regs #(
    parameter int num_endpoints = 8,                  // endpoint registers
    parameter int frame_cycles = `FRAME_CYCLES        // cycles per frame
) (
    input wire logic clock,
    input wire logic srst,
    input wire usb_frame_pkg::reg_addr_type reg_addr,
    input wire usb_frame_pkg::word_type reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output usb_frame_pkg::word_type reg_rdata,
    input wire logic dplus_pin,
    input wire logic dminus_pin,
    input wire logic sof_received,
    input wire logic [10:0] sof_frame,
    input wire logic bus_reset_event,
    input wire logic resume_done,
    input wire logic bus_traffic,
    input wire logic token_valid,
    input wire logic [6:0] token_addr,
    input wire logic [3:0] token_endp,
    input wire logic setup_seen,
    input wire logic rx_ack,
    input wire logic rx_end,
    input wire logic tx_done,
    output logic txn_accept,
    output logic [2:0] txn_ep_index,
    output logic table_fetch_req,
    output logic [15:0] table_fetch_addr,
    output logic missed_frame_event,
    output logic suspend_request_event,
    output logic ep_irq,
    output logic complete_irq
);
    import usb_frame_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (num_endpoints < 1 || num_endpoints > 8) begin : g_bad_count
        $error("endpoint count must be 1 to 8");
    end
    if (frame_cycles < 4 || frame_cycles > 65535) begin : g_bad_frame
        $error("frame cycle count out of range");
    end

    localparam logic [15:0] frame_limit = 16'(frame_cycles - 1);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [10:0] frame_count_field;          // last frame number
    logic frame_timer_locked;                // two frames in a row seen
    logic [1:0] missed_start_count;          // lost frames in a row
    logic [1:0] good_frames;                 // frames since reset/resume
    logic [1:0] idle_missed;                 // misses with no traffic
    logic [15:0] frame_timer;                // cycles since last frame
    logic [1:0] dplus_sync;                  // line synchroniser
    logic [1:0] dminus_sync;                 // line synchroniser
    logic function_enable;                   // transactions allowed
    logic [6:0] device_number_field;         // assigned device address
    logic [12:0] buffer_table_base;          // table base, bits 15:3
    logic force_bus_reset;                   // software reset request
    logic complete_irq_mask;                 // generic condition gate
    logic [2:0] current_ep;                  // endpoint of open transaction
    logic ep_rx_flag [num_endpoints];        // reception completed
    logic ep_rx_toggle [num_endpoints];      // expected data pid
    logic ep_tx_flag [num_endpoints];        // transmission completed
    ep_kind_type ep_kind [num_endpoints];    // transfer kind
    logic [3:0] ep_number [num_endpoints];   // endpoint number field

    logic any_reset;                         // bus or forced reset
    logic ep_hit;                            // write/read hits an endpoint
    logic [2:0] ep_sel;                      // endpoint selected by address
    logic match_found;                       // token matched an endpoint
    logic [2:0] match_index;                 // lowest matching endpoint

    // ****************************************************************
    // decoding helpers
    // ****************************************************************
    // whether the address is a valid endpoint slot
    function automatic logic ep_addr_ok(input logic [6:0] addr);
        logic [6:0] idx;
        idx = addr >> 2;
        return (addr[1:0] == 2'h0) && (idx < 7'(num_endpoints));
    endfunction : ep_addr_ok

    // is the token for this endpoint slot
    function automatic logic ep_matches(input int i, input logic [3:0] endp);
        return ep_number[i] == endp;
    endfunction : ep_matches

    assign any_reset = bus_reset_event | force_bus_reset;
    assign ep_hit = ep_addr_ok(reg_addr);
    assign ep_sel = reg_addr[4:2];

    // lowest slot wins when numbers repeat
    always_comb begin
        match_found = 1'b0;
        match_index = 3'h0;
        for (int i = num_endpoints - 1; i >= 0; i--) begin
            if (ep_matches(i, token_endp)) begin
                match_found = 1'b1;
                match_index = 3'(i);
            end
        end
    end

    // ****************************************************************
    // line level synchronisers
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            dplus_sync <= 2'h0;
            dminus_sync <= 2'h0;
        end else begin
            dplus_sync <= {dplus_sync[0], dplus_pin};
            dminus_sync <= {dminus_sync[0], dminus_pin};
        end
    end

    // ****************************************************************
    // frame tracking
    // ****************************************************************
    // frame number capture
    always_ff @(posedge clock) begin
        if (srst) begin
            frame_count_field <= 11'h000;
        end else if (sof_received) begin
            frame_count_field <= sof_frame;
        end
    end

    // frame timer and missed frame pulse
    always_ff @(posedge clock) begin
        if (srst) begin
            frame_timer <= 16'h0000;
            missed_frame_event <= 1'b0;
        end else begin
            missed_frame_event <= 1'b0;
            if (sof_received || bus_reset_event) begin
                frame_timer <= 16'h0000;
            end else if (frame_timer == frame_limit) begin
                frame_timer <= 16'h0000;
                missed_frame_event <= 1'b1;
            end else begin
                frame_timer <= frame_timer + 16'h0001;
            end
        end
    end

    // lost count, saturating
    always_ff @(posedge clock) begin
        if (srst) begin
            missed_start_count <= 2'h0;
        end else if (sof_received) begin
            missed_start_count <= 2'h0;
        end else if (missed_frame_event && missed_start_count != 2'h3) begin
            missed_start_count <= missed_start_count + 2'h1;
        end
    end

    // lock after two frames in a row
    always_ff @(posedge clock) begin
        if (srst) begin
            good_frames <= 2'h0;
            frame_timer_locked <= 1'b0;
        end else if (bus_reset_event || suspend_request_event) begin
            good_frames <= 2'h0;
            frame_timer_locked <= 1'b0;
        end else if (resume_done || missed_frame_event) begin
            good_frames <= 2'h0;
        end else if (sof_received && good_frames != 2'h2) begin
            good_frames <= good_frames + 2'h1;
            if (good_frames == 2'h1) begin
                frame_timer_locked <= 1'b1;
            end
        end
    end

    // suspend after three idle misses
    always_ff @(posedge clock) begin
        if (srst) begin
            idle_missed <= 2'h0;
            suspend_request_event <= 1'b0;
        end else begin
            suspend_request_event <= 1'b0;
            if (bus_traffic || sof_received) begin
                idle_missed <= 2'h0;
            end else if (missed_frame_event) begin
                if (idle_missed == `MISSED_FOR_SUSPEND - 2'h1) begin
                    idle_missed <= 2'h0;
                    suspend_request_event <= 1'b1;
                end else begin
                    idle_missed <= idle_missed + 2'h1;
                end
            end
        end
    end

    // ****************************************************************
    // function address, table base, control
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst || any_reset) begin
            function_enable <= 1'b0;
            device_number_field <= 7'h00;
        end else if (reg_write && reg_addr == `FUNCTION_ADDRESS_OFFSET) begin
            function_enable <= reg_wdata[`FA_ENABLE_BIT];
            device_number_field <= reg_wdata[`FA_NUMBER_HI:0];
        end
    end

    // table base keeps only bits 15:3
    always_ff @(posedge clock) begin
        if (srst) begin
            buffer_table_base <= 13'h0000;
        end else if (reg_write && reg_addr == `TABLE_BASE_OFFSET) begin
            buffer_table_base <= reg_wdata[15:`TB_BASE_LO];
        end
    end

    // software reset and mask bits
    always_ff @(posedge clock) begin
        if (srst) begin
            force_bus_reset <= 1'b0;
            complete_irq_mask <= 1'b0;
        end else if (reg_write && reg_addr == `CONTROL_OFFSET) begin
            force_bus_reset <= reg_wdata[`CTL_FORCE_RESET_BIT];
            complete_irq_mask <= reg_wdata[`CTL_IRQ_MASK_BIT];
        end
    end

    // ****************************************************************
    // token matching and table fetch
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            txn_accept <= 1'b0;
            table_fetch_req <= 1'b0;
            txn_ep_index <= 3'h0;
            table_fetch_addr <= 16'h0000;
            current_ep <= 3'h0;
        end else begin
            txn_accept <= 1'b0;
            table_fetch_req <= 1'b0;
            if (token_valid && function_enable && !any_reset
                && token_addr == device_number_field && match_found) begin
                txn_accept <= 1'b1;
                table_fetch_req <= 1'b1;
                txn_ep_index <= match_index;
                current_ep <= match_index;
                table_fetch_addr <= {buffer_table_base, 3'h0} + {10'h000, match_index, 3'h0};
            end
        end
    end

    // ****************************************************************
    // endpoint registers
    // ****************************************************************
    for (genvar i = 0; i < num_endpoints; i++) begin : g_ep
        logic wr_hit;     // software write to this slot
        logic here;       // event targets this slot
        assign wr_hit = reg_write && ep_hit && ep_sel == 3'(i);
        assign here = current_ep == 3'(i);

        // completion flags: hardware set wins over software clear
        always_ff @(posedge clock) begin
            if (srst) begin
                ep_rx_flag[i] <= 1'b0;
                ep_tx_flag[i] <= 1'b0;
            end else begin
                ep_rx_flag[i] <= (here && rx_ack)
                    | (ep_rx_flag[i] & ~(wr_hit && !reg_wdata[`EP_RX_FLAG_BIT]));
                ep_tx_flag[i] <= (here && tx_done)
                    | (ep_tx_flag[i] & ~(wr_hit && !reg_wdata[`EP_TX_FLAG_BIT]));
            end
        end

        // reception toggle
        always_ff @(posedge clock) begin
            if (srst || any_reset) begin
                ep_rx_toggle[i] <= 1'b0;
            end else begin
                if (here && setup_seen && ep_kind[i] == kind_control) begin
                    ep_rx_toggle[i] <= wr_hit && reg_wdata[`EP_RX_TOGGLE_BIT];
                end else begin
                    ep_rx_toggle[i] <= ep_rx_toggle[i]
                        ^ (wr_hit && reg_wdata[`EP_RX_TOGGLE_BIT])
                        ^ (here && rx_ack && ep_kind[i] != kind_iso)
                        ^ (here && rx_end && ep_kind[i] == kind_iso);
                end
            end
        end

        // kind and endpoint number
        always_ff @(posedge clock) begin
            if (srst || any_reset) begin
                ep_kind[i] <= kind_bulk;
                ep_number[i] <= 4'h0;
            end else if (wr_hit) begin
                ep_kind[i] <= ep_kind_type'(reg_wdata[`EP_KIND_HI:`EP_KIND_LO]);
                ep_number[i] <= reg_wdata[`EP_NUMBER_HI:0];
            end
        end
    end

    // ****************************************************************
    // interrupt conditions
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            ep_irq <= 1'b0;
            complete_irq <= 1'b0;
        end else begin
            ep_irq <= 1'b0;
            for (int i = 0; i < num_endpoints; i++) begin
                if (ep_rx_flag[i] || ep_tx_flag[i]) begin
                    ep_irq <= 1'b1;
                end
            end
            complete_irq <= 1'b0;
            for (int i = 0; i < num_endpoints; i++) begin
                if ((ep_rx_flag[i] || ep_tx_flag[i]) && complete_irq_mask) begin
                    complete_irq <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // read port, data one cycle after the strobe
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= `WORD_RESET;
        end else if (reg_read) begin
            reg_rdata <= `WORD_RESET;
            if (ep_hit) begin
                reg_rdata[`EP_RX_FLAG_BIT] <= ep_rx_flag[ep_sel];
                reg_rdata[`EP_RX_TOGGLE_BIT] <= ep_rx_toggle[ep_sel];
                reg_rdata[`EP_KIND_HI:`EP_KIND_LO] <= ep_kind[ep_sel];
                reg_rdata[`EP_TX_FLAG_BIT] <= ep_tx_flag[ep_sel];
                reg_rdata[`EP_NUMBER_HI:0] <= ep_number[ep_sel];
            end else if (reg_addr == `FRAME_STATUS_OFFSET) begin
                reg_rdata <= {dplus_sync[1], dminus_sync[1], frame_timer_locked,
                    missed_start_count, frame_count_field};
            end else if (reg_addr == `FUNCTION_ADDRESS_OFFSET) begin
                reg_rdata <= {8'h00, function_enable, device_number_field};
            end else if (reg_addr == `TABLE_BASE_OFFSET) begin
                reg_rdata <= {buffer_table_base, 3'h0};
            end else if (reg_addr == `CONTROL_OFFSET) begin
                reg_rdata <= {14'h0000, complete_irq_mask, force_bus_reset};
            end
        end else begin
            reg_rdata <= `WORD_RESET;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_two_frames;
        sof_received ##1 frame_timer_locked;
    endsequence

    property p_frame_capture;
        @(posedge clock) disable iff (srst) sof_received |=> frame_count_field == $past(sof_frame);
    endproperty
    a_frame_capture: assert property (p_frame_capture) else $error("frame number not captured");

    property p_lock_cause;
        @(posedge clock) disable iff (srst) $rose(frame_timer_locked) |-> $past(sof_received);
    endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock without a frame");

    property p_lock_drop;
        @(posedge clock) disable iff (srst) bus_reset_event |=> !frame_timer_locked;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock kept over bus reset");

    property p_lost_clear;
        @(posedge clock) disable iff (srst) sof_received |=> missed_start_count == 2'h0;
    endproperty
    a_lost_clear: assert property (p_lost_clear) else $error("lost count not cleared");

    property p_addr_reset;
        @(posedge clock) disable iff (srst) any_reset |=> device_number_field == 7'h00 && !function_enable;
    endproperty
    a_addr_reset: assert property (p_addr_reset) else $error("address kept over reset");

    property p_disabled;
        @(posedge clock) disable iff (srst) (token_valid && !function_enable) |=> !txn_accept;
    endproperty
    a_disabled: assert property (p_disabled) else $error("transaction while disabled");

    property p_fetch;
        @(posedge clock) disable iff (srst)
            txn_accept |-> table_fetch_req && table_fetch_addr[2:0] == 3'h0
                && table_fetch_addr[15:3] == buffer_table_base + 13'(txn_ep_index);
    endproperty
    a_fetch: assert property (p_fetch) else $error("table fetch address wrong");

    property p_rx_set;
        @(posedge clock) disable iff (srst || any_reset) rx_ack |=> ep_rx_flag[$past(current_ep)];
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("completion flag not set");

    property p_irq;
        @(posedge clock) disable iff (srst) (ep_rx_flag[0] && complete_irq_mask) |=> ep_irq && complete_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("completion condition missing");

    property p_suspend;
        @(posedge clock) disable iff (srst) suspend_request_event |-> $past(missed_frame_event);
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend without missed frame");

    property p_missed_single;
        @(posedge clock) disable iff (srst) missed_frame_event |=> !missed_frame_event [*3];
    endproperty
    a_missed_single: assert property (p_missed_single) else $error("missed frame repeated");

endmodule : usb_frame_regs
`default_nettype wire

// [usb_frame_map.svh]
// register offsets, field positions, reset values and timing counts
// assumes byte addresses on a 7-bit register port, 16-bit registers in word slots
`ifndef USB_FRAME_MAP_SVH
`define USB_FRAME_MAP_SVH
// ****************************************************************
// offsets
// ****************************************************************
`define EP_REG_BASE 7'h00
`define EP_REG_STRIDE 7'h04
`define FRAME_STATUS_OFFSET 7'h48
`define FUNCTION_ADDRESS_OFFSET 7'h4c
`define TABLE_BASE_OFFSET 7'h50
`define CONTROL_OFFSET 7'h40
// ****************************************************************
// field positions
// ****************************************************************
`define EP_RX_FLAG_BIT 15
`define EP_RX_TOGGLE_BIT 14
`define EP_KIND_HI 10
`define EP_KIND_LO 9
`define EP_TX_FLAG_BIT 7
`define EP_NUMBER_HI 3
`define FS_DPLUS_BIT 15
`define FS_DMINUS_BIT 14
`define FS_LOCK_BIT 13
`define FS_LOST_HI 12
`define FS_LOST_LO 11
`define FS_FRAME_HI 10
`define FA_ENABLE_BIT 7
`define FA_NUMBER_HI 6
`define TB_BASE_LO 3
`define CTL_FORCE_RESET_BIT 0
`define CTL_IRQ_MASK_BIT 1
// ****************************************************************
// reset values and timing
// ****************************************************************
`define WORD_RESET 16'h0000
`define CLOCK_PERIOD_NS 40
`define FRAME_PERIOD_NS 1000000
`define FRAME_CYCLES (`FRAME_PERIOD_NS / `CLOCK_PERIOD_NS)
`define MISSED_FOR_SUSPEND 2'h3
`endif

// [usb_frame_pkg.sv]
// types shared by the frame, address and endpoint register block
// assumes the constants header is included where numbers are needed
package usb_frame_pkg;
    typedef logic [15:0] word_type;        // one register word
    typedef logic [6:0] reg_addr_type;     // register port byte address
    typedef enum logic [1:0] {
        kind_bulk,
        kind_control,
        kind_iso,
        kind_interrupt
    } ep_kind_type;                        // endpoint transfer kind
endpackage : usb_frame_pkg

// [usb_host_model.sv]
// host side model: start-of-frame packets and idle upstream line levels
// assumes send_sof is pulsed by the bench just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host model
// ****************************************************************
module usb_host_model (
    input wire logic clock,
    input wire logic send_sof,
    output logic sof_received = 1'b0,
    output logic [10:0] sof_frame = 11'h000,
    output logic dplus_pin,
    output logic dminus_pin
);
    logic [10:0] next_frame = 11'h123; // number of the next frame sent
    // idle full-speed bus: d+ high, d- low
    assign dplus_pin = 1'b1;
    assign dminus_pin = 1'b0;
    // one packet per request; frame field scrambled between packets
    always @(posedge clock) begin
        sof_received <= send_sof;
        sof_frame <= send_sof ? next_frame : ~sof_frame;
        if (send_sof) begin
            next_frame <= next_frame + 11'h001;
        end
    end
endmodule : usb_host_model
`default_nettype wire

// [usb_device_frame_addr_endpoint_regs_tb_top.sv]
// self-checking bench for the frame, address and endpoint register block
// assumes the design's package and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// bench top
// ****************************************************************
module usb_device_frame_addr_endpoint_regs_tb_top;
    import usb_frame_pkg::*;
    logic clock = 1'b0, srst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, send_sof = 1'b0;
    logic token_valid = 1'b0, setup_seen = 1'b0, rx_ack = 1'b0, idle = 1'b0; // idle: tied inputs
    logic bus_reset = 1'b0, rx_end = 1'b0, suspend_request_event;
    logic [2:0] txn_ep_index;
    logic sof_received, dplus_pin, dminus_pin, txn_accept, table_fetch_req, missed_frame_event;
    logic ep_irq, complete_irq;
    logic [10:0] sof_frame;
    logic [6:0] token_addr = 7'h00;
    logic [3:0] token_endp = 4'h0;
    logic [15:0] table_fetch_addr;
    reg_addr_type reg_addr = 7'h00;
    word_type reg_wdata = 16'h0000, reg_rdata;
    int mismatches = 0, tests_run = 0;
    logic [38:0] rows [6] = '{ // address, write data, expected read back
        {7'h48, 16'hffff, 16'h8000}, {7'h4c, 16'hffff, 16'h00ff}, {7'h50, 16'hffff, 16'hfff8},
        {7'h5c, 16'hffff, 16'h0000}, {7'h00, 16'hc201, 16'h4201}, {7'h00, 16'h4201, 16'h0201}};
    always #20 clock = ~clock;
    usb_host_model host (.clock(clock), .send_sof(send_sof), .sof_received(sof_received),
        .sof_frame(sof_frame), .dplus_pin(dplus_pin), .dminus_pin(dminus_pin));
    usb_frame_regs #(.frame_cycles(200)) dut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .dplus_pin(dplus_pin), .dminus_pin(dminus_pin), .sof_received(sof_received),
        .sof_frame(sof_frame), .bus_reset_event(bus_reset), .resume_done(idle), .bus_traffic(idle),
        .token_valid(token_valid), .token_addr(token_addr), .token_endp(token_endp),
        .setup_seen(setup_seen), .rx_ack(rx_ack), .rx_end(rx_end), .tx_done(idle),
        .txn_accept(txn_accept), .txn_ep_index(txn_ep_index), .table_fetch_req(table_fetch_req),
        .table_fetch_addr(table_fetch_addr), .missed_frame_event(missed_frame_event),
        .suspend_request_event(suspend_request_event), .ep_irq(ep_irq), .complete_irq(complete_irq));
    // compare and count
    task automatic check(input word_type seen, input word_type expected);
        tests_run++;
        if (seen !== expected) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check
    task automatic wr(input reg_addr_type a, input word_type d);
        @(posedge clock) begin reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d; end
        @(posedge clock) reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input reg_addr_type a, input word_type e);
        @(posedge clock) begin reg_read <= 1'b1; reg_addr <= a; end
        @(posedge clock) reg_read <= 1'b0;
        #1 check(reg_rdata, e);
    endtask : rd
    // one-cycle token, then look at the accept pulse
    task automatic token(input logic [6:0] a, input logic [3:0] n, input logic e);
        @(posedge clock) begin token_valid <= 1'b1; token_addr <= a; token_endp <= n; end
        @(posedge clock) token_valid <= 1'b0;
        #1 check({15'h0, txn_accept}, {15'h0, e});
        check({15'h0, table_fetch_req}, {15'h0, e});
    endtask : token
    task automatic give_verdict;
        if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        give_verdict();
    end
    // main sequence: rows, then hand-written cases
    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i][38:32], rows[i][31:16]);
            rd(rows[i][38:32], rows[i][15:0]);
        end
        token(7'h7f, 4'h2, 1'b0);
        token(7'h7f, 4'h1, 1'b1);
        check(table_fetch_addr, 16'hfff8);
        @(posedge clock) rx_ack <= 1'b1;
        @(posedge clock) rx_ack <= 1'b0;
        rd(7'h00, 16'hc201);
        check({14'h0000, ep_irq, complete_irq}, 16'h0002);
        @(posedge clock) setup_seen <= 1'b1;
        @(posedge clock) setup_seen <= 1'b0;
        rd(7'h00, 16'h8201);
        repeat (2) begin
            @(posedge clock) send_sof <= 1'b1;
            @(posedge clock) send_sof <= 1'b0;
        end
        rd(7'h48, 16'ha124);
        for (int k = 0; k < 300 && missed_frame_event !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        rd(7'h48, 16'ha924);
        wr(7'h40, 16'h0001);
        wr(7'h40, 16'h0000);
        rd(7'h4c, 16'h0000);
        rd(7'h00, 16'h8000);
        token(7'h00, 4'h0, 1'b0);
        wr(7'h40, 16'h0002);
        rd(7'h40, 16'h0002);
        check({14'h0000, ep_irq, complete_irq}, 16'h0003);
        for (int k = 0; k < 500 && suspend_request_event !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        check({15'h0000, suspend_request_event}, 16'h0001);
        rd(7'h48, 16'h9924);
        wr(7'h4c, 16'h0085);
        @(posedge clock) bus_reset <= 1'b1;
        @(posedge clock) bus_reset <= 1'b0;
        rd(7'h4c, 16'h0000);
        wr(7'h4c, 16'h0085);
        wr(7'h50, 16'h0100);
        wr(7'h04, 16'h8482);
        token(7'h05, 4'h2, 1'b1);
        check(table_fetch_addr, 16'h0108);
        check({13'h0000, txn_ep_index}, 16'h0001);
        @(posedge clock) rx_end <= 1'b1;
        @(posedge clock) rx_end <= 1'b0;
        rd(7'h04, 16'h4402);
        rd(7'h00, 16'h8000);
        give_verdict();
    end
endmodule : usb_device_frame_addr_endpoint_regs_tb_top
`default_nettype wire
